// ---- rfc_cfg.svh ----
// Register offsets, field positions, reset values and timing counts for the
// resistance-to-frequency converter.
// Assumes inclusion by name from the package and design files.
`ifndef RFC_CFG_SVH
`define RFC_CFG_SVH
`define RFC_CTRL_ADDR 8'ha6
`define RFC_CTRL_RESET 8'h00
`define RFC_ENABLE_BIT 7
`define RFC_FIXED5_BIT 5
`define RFC_FIXED4_BIT 4
`define RFC_OUTEN_BIT 3
`define RFC_CHAN_LSB 0
`define RFC_CHAN_MSB 2
`define RFC_NUM_CHAN 5
`define RFC_CAP_HIGH 2'h1
`define RFC_CAP_LOW 2'h2
`define RFC_CAP_CYCLE 2'h3
`define RFC_DEAD_NS 10
`define RFC_CLK_NS 10
`define RFC_DEAD_CYC (((`RFC_DEAD_NS) + (`RFC_CLK_NS) - 1) / (`RFC_CLK_NS))
`endif

// ---- rfc_osc_ctl.sv ----
// Relaxation oscillator control for one selected channel pin.
// Assumes the pin input is the Schmitt trigger level, synchronous to clk.
`timescale 1ns/1ns
module rfc_osc_ctl (
   input wire logic clk,
   input wire logic rstn,
   input wire logic run,
   input wire logic schmittIn,
   output rfc_pkg::rfc_state_t state,
   output logic oscClk
);
   import rfc_pkg::*;
   rfc_state_t state_reg;
   rfc_state_t state_next;
   logic osc_reg;
   wire logic toDis = (state_reg == RFC_CHARGE) && schmittIn;
   wire logic toChg = (state_reg == RFC_DISCHARGE) && !schmittIn;
   always_comb begin
      state_next = state_reg;
      case (state_reg)
         RFC_IDLE: begin
            if (run) begin
               state_next = RFC_CHARGE;
            end
         end
         RFC_CHARGE: begin
            if (!run) begin
               state_next = RFC_IDLE;
            end else if (toDis) begin
               state_next = RFC_DISCHARGE;
            end
         end
         RFC_DISCHARGE: begin
            if (!run) begin
               state_next = RFC_IDLE;
            end else if (toChg) begin
               state_next = RFC_CHARGE;
            end
         end
         default: begin
            state_next = RFC_IDLE;
         end
      endcase
   end
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         state_reg <= RFC_IDLE;
         osc_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         osc_reg <= (state_next == RFC_CHARGE);
      end
   end
   assign state = state_reg;
   assign oscClk = osc_reg;
endmodule : rfc_osc_ctl

// ---- rfc_pkg.sv ----
// Types shared by the converter design files.
// Assumes rfc_cfg.svh is on the include path.
`include "rfc_cfg.svh"
package rfc_pkg;
   typedef struct packed {
      logic [4:0] out;
      logic [4:0] oe;
      logic [4:0] gpioOwn;
   } rfc_pins_t;
   typedef enum logic [1:0] {
      RFC_IDLE = 2'h0,
      RFC_CHARGE = 2'h1,
      RFC_DISCHARGE = 2'h3
   } rfc_state_t;
   typedef enum logic [1:0] {
      RFC_CAP_OFF = 2'h0,
      RFC_CAP_HI = 2'h1,
      RFC_CAP_LO = 2'h2,
      RFC_CAP_CYC = 2'h3
   } rfc_cap_t;
endpackage : rfc_pkg

// ---- rfc_rc_model.sv ----
// Resistor and capacitor on each channel pin, read through a Schmitt input.
// Assumes pin drive is sampled on the bench clock.
`timescale 1ns/1ns
module rfc_rc_model #(
   parameter int DLY = 6
) (
   input wire logic clk,
   input wire logic [4:0] drv,
   input wire logic [4:0] drvOe,
   output logic [4:0] level
);
   int q [5] = '{default: 0};
   initial level = 5'h00;
   always @(posedge clk) begin
      for (int i = 0; i < 5; i++) begin
         if (drvOe[i] && !drv[i]) begin
            q[i] = (q[i] > 0) ? q[i] - 1 : 0;
         end else begin
            q[i] = (q[i] < DLY) ? q[i] + 1 : DLY;
         end
         if (q[i] == DLY) level[i] <= 1'b1;
         if (q[i] == 0) level[i] <= 1'b0;
      end
   end
endmodule : rfc_rc_model

// ---- rfc_top.sv ----
// Resistance-to-frequency converter control: register, pin sharing,
// oscillator drive and a capture timer on the converted clock.
// Assumes synchronous pin inputs and a single-cycle strobe register port.
`timescale 1ns/1ns
`include "rfc_cfg.svh"
//
// Contract
// - There are five channels, channel 0 the reference and 1 to 4 sensors.
// - Select codes 0 to 4 take one pin from GPIO; codes 5 to 7 take none.
// - With the enable bit clear the selected pin stays GPIO.
// - Pins not selected stay GPIO.
// - Control bit 7 enables the converter.
// - Control bit 3 routes the oscillation clock to the shared output pin.
// - The selected pin charges until high, discharges until low, repeating.
// - The charge and discharge phases form a digital clock.
// - The converted clock feeds the capture timer as a clock source; here the timer counts clk cycles between its edges.
// - The timer measures pulse width or frequency of the converted clock.
// - Oscillation continues in low-power mode and never raises wake-up.
// - Capture select 01 high width, 10 low width, 11 full cycle.
module rfc_top #(
   parameter int NCHAN = `RFC_NUM_CHAN,
   parameter int CNTW = 16
) (
   input wire logic clk,
   input wire logic rstn,
   input wire logic [7:0] regAddr,
   input wire logic [7:0] regWdata,
   input wire logic regWr,
   input wire logic regRd,
   output logic [7:0] regRdata,
   input wire logic [NCHAN-1:0] chanIn,
   input wire logic [NCHAN-1:0] gpioOut,
   input wire logic [NCHAN-1:0] gpioOe,
   output logic [NCHAN-1:0] chanOut,
   output logic [NCHAN-1:0] chanOe,
   input wire logic sharedGpioOut,
   input wire logic sharedGpioOe,
   output logic sharedOut,
   output logic sharedOe,
   input wire logic [1:0] captureSel,
   input wire logic captureStart,
   input wire logic greenMode,
   output logic oscClkOut,
   output logic [CNTW-1:0] captureValue,
   output logic captureDone,
   output logic wakeReq
);
   import rfc_pkg::*;

   logic [7:0] ctrl_reg;
   logic [7:0] rdata_reg;
   logic [NCHAN-1:0] out_reg;
   logic [NCHAN-1:0] oe_reg;
   logic sOut_reg;
   logic sOe_reg;
   logic oscOut_reg;
   logic [CNTW-1:0] cnt_reg;
   logic [CNTW-1:0] cap_reg;
   logic done_reg;
   logic armed_reg;
   logic seen_reg;
   logic oscPrev_reg;
   logic wake_reg;
   rfc_state_t oscState;
   logic oscClk;

   // Bits 5 and 4 are write-only and hold no storage; bit 6 is unused.
   wire logic ctrlHit = (regAddr == `RFC_CTRL_ADDR);
   wire logic ctrlWr = regWr && ctrlHit;
   wire logic [7:0] ctrlNext = {regWdata[`RFC_ENABLE_BIT], 3'h0,
      regWdata[`RFC_OUTEN_BIT], regWdata[`RFC_CHAN_MSB:`RFC_CHAN_LSB]};
   wire logic [7:0] ctrlView = {ctrl_reg[`RFC_ENABLE_BIT], 3'h0,
      ctrl_reg[`RFC_OUTEN_BIT], ctrl_reg[`RFC_CHAN_MSB:`RFC_CHAN_LSB]};
   wire logic convEnable = ctrl_reg[`RFC_ENABLE_BIT];
   wire logic outEnable = ctrl_reg[`RFC_OUTEN_BIT];
   wire logic [2:0] chanSel = ctrl_reg[`RFC_CHAN_MSB:`RFC_CHAN_LSB];
   wire logic chanValid = (chanSel < 3'(NCHAN));
   wire logic run = convEnable && chanValid;

   // One-hot ownership of the channel pins by the converter.
   logic [NCHAN-1:0] own;
   genvar g;
   generate
      for (g = 0; g < NCHAN; g++) begin : gOwn
         assign own[g] = run && (chanSel == 3'(g));
      end
   endgenerate

   // The selected pin reads back through its Schmitt input; greenMode is
   // deliberately not used so the oscillator keeps running.
   wire logic selIn = chanValid ? chanIn[chanSel] : 1'b0;
   wire logic chargeDrive = (oscState == RFC_CHARGE);

   rfc_osc_ctl uOsc (
      .clk(clk),
      .rstn(rstn),
      .run(run),
      .schmittIn(selIn),
      .state(oscState),
      .oscClk(oscClk)
   );

   // Converter drives high to charge and low to discharge the capacitor.
   wire logic [NCHAN-1:0] pinOutNext = (own & {NCHAN{chargeDrive}})
      | (~own & gpioOut);
   wire logic [NCHAN-1:0] pinOeNext = (own & {NCHAN{run}})
      | (~own & gpioOe);

   wire logic sOutNext = outEnable ? oscClk : sharedGpioOut;
   wire logic sOeNext = outEnable ? 1'b1 : sharedGpioOe;

   // Capture timer on the converted clock edges.
   wire logic rise = oscClk && !oscPrev_reg;
   wire logic fall = !oscClk && oscPrev_reg;
   wire logic capHi = (captureSel == `RFC_CAP_HIGH);
   wire logic capLo = (captureSel == `RFC_CAP_LOW);
   wire logic capCyc = (captureSel == `RFC_CAP_CYCLE);
   wire logic startEdge = (capHi && rise) || (capLo && fall)
      || (capCyc && rise);
   wire logic stopEdge = (capHi && fall) || (capLo && rise)
      || (capCyc && rise);
   wire logic counting = armed_reg && seen_reg;
   wire logic finish = counting && stopEdge;
   // The count saturates so a stalled sensor never wraps to a small value.
   wire logic cntFull = (cnt_reg == {CNTW{1'b1}});
   wire logic [CNTW-1:0] cntInc = cntFull ? cnt_reg : cnt_reg + CNTW'(1);

   // An abort on disable wins, then a start request, then the stop edge.
   wire logic capArm = captureStart && run && (captureSel != 2'h0);
   wire logic capWrite = !capArm && run && finish;
   wire logic capFirst = !capArm && run && armed_reg && !seen_reg
      && startEdge;
   wire logic capStep = !capArm && run && counting && !finish;
   wire logic armed_next = capArm || (armed_reg && run && !finish);
   wire logic seen_next = capFirst
      || (!capArm && run && !finish && seen_reg);
   wire logic [CNTW-1:0] cnt_next = (capArm || capFirst) ? '0
      : (capStep ? cntInc : cnt_reg);
   wire logic [CNTW-1:0] cap_next = capWrite ? cntInc : cap_reg;

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         ctrl_reg <= `RFC_CTRL_RESET;
      end else if (ctrlWr) begin
         ctrl_reg <= ctrlNext;
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         rdata_reg <= 8'h00;
      end else begin
         rdata_reg <= (regRd && ctrlHit) ? ctrlView : 8'h00;
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         out_reg <= '0;
      end else begin
         out_reg <= pinOutNext;
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         oe_reg <= '0;
      end else begin
         oe_reg <= pinOeNext;
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         sOut_reg <= 1'b0;
      end else begin
         sOut_reg <= sOutNext;
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         sOe_reg <= 1'b0;
      end else begin
         sOe_reg <= sOeNext;
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         oscOut_reg <= 1'b0;
      end else begin
         oscOut_reg <= oscClk;
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         oscPrev_reg <= 1'b0;
      end else begin
         oscPrev_reg <= oscClk;
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         armed_reg <= 1'b0;
      end else begin
         armed_reg <= armed_next;
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         seen_reg <= 1'b0;
      end else begin
         seen_reg <= seen_next;
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         cnt_reg <= '0;
      end else begin
         cnt_reg <= cnt_next;
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         cap_reg <= '0;
      end else begin
         cap_reg <= cap_next;
      end
   end

   // The done pulse marks exactly the cycles in which a result is stored.
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         done_reg <= 1'b0;
      end else begin
         done_reg <= capWrite;
      end
   end

   // Converter activity never asks for wake-up, in green mode or not.
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         wake_reg <= 1'b0;
      end else begin
         wake_reg <= 1'b0;
      end
   end

   assign regRdata = rdata_reg;
   assign chanOut = out_reg;
   assign chanOe = oe_reg;
   assign sharedOut = sOut_reg;
   assign sharedOe = sOe_reg;
   assign oscClkOut = oscOut_reg;
   assign captureValue = cap_reg;
   assign captureDone = done_reg;
   assign wakeReq = wake_reg;
endmodule : rfc_top

// ---- rfc_top_sva.sv ----
// Assertion checker for the converter top: register port and pin sharing.
// Assumes it is bound to rfc_top and sees only that module's ports.
`timescale 1ns/1ns
`include "rfc_cfg.svh"
module rfc_top_sva #(
   parameter int NCHAN = 5
) (
   input wire logic clk,
   input wire logic rstn,
   input wire logic [7:0] regAddr,
   input wire logic [7:0] regWdata,
   input wire logic regWr,
   input wire logic regRd,
   input wire logic [7:0] regRdata,
   input wire logic [NCHAN-1:0] chanIn,
   input wire logic [NCHAN-1:0] gpioOut,
   input wire logic [NCHAN-1:0] gpioOe,
   input wire logic [NCHAN-1:0] chanOut,
   input wire logic [NCHAN-1:0] chanOe,
   input wire logic sharedGpioOe,
   input wire logic sharedOe,
   input wire logic oscClkOut,
   input wire logic wakeReq
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rstn);
   logic [7:0] ctrlReg;
   logic [NCHAN-1:0] ownReg, own1Reg, own2Reg;
   wire ctlHit = regAddr == `RFC_CTRL_ADDR;
   wire [NCHAN-1:0] ownNow = (ctrlReg[7] && ctrlReg[2:0] < 3'h5) ?
      NCHAN'(1) << ctrlReg[2:0] : '0;
   wire [NCHAN-1:0] freeMask = ~(ownNow | ownReg | own1Reg | own2Reg);
   wire [NCHAN-1:0] steady = ownNow & ownReg & own1Reg & own2Reg;
   wire selLive = |steady;
   wire inSel = |(chanIn & steady);
   wire outSel = |(chanOut & steady);
   // Shadow of the control byte; bits 6 to 4 are never stored.
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         ctrlReg <= 8'h00;
         ownReg <= '0;
         own1Reg <= '0;
         own2Reg <= '0;
      end else begin
         if (regWr && ctlHit) ctrlReg <= regWdata & 8'h8f;
         ownReg <= ownNow;
         own1Reg <= ownReg;
         own2Reg <= own1Reg;
      end
   end
   sequence s_top; selLive && $past(selLive) && $rose(inSel); endsequence
   sequence s_bottom; selLive && $past(selLive) && $fell(inSel); endsequence
   property p_rd; regRd && ctlHit |=> regRdata == $past(ctrlReg); endproperty
   property p_unmap; regRd && !ctlHit |=> regRdata == 8'h00; endproperty
   property p_free; $past(rstn, 2) |-> (((chanOe ^ $past(gpioOe)) |
      (chanOut ^ $past(gpioOut))) & freeMask) == '0; endproperty
   property p_hold; selLive |-> (chanOe & steady) == steady; endproperty
   property p_swap; s_top |-> ##[1:3] !outSel; endproperty
   property p_refill; s_bottom |-> ##[1:3] (outSel || !selLive); endproperty
   property p_shOn; ctrlReg[3] [*3] |-> sharedOe; endproperty
   property p_shOff; $past(rstn, 2) && !ctrlReg[3] [*3] |->
      sharedOe == $past(sharedGpioOe); endproperty
   property p_stop; !ctrlReg[7] [*5] |-> $stable(oscClkOut); endproperty
   property p_wake; !wakeReq; endproperty
   a_rd: assert property (p_rd) else $error("read data wrong");
   a_unmap: assert property (p_unmap) else $error("unmapped read");
   a_free: assert property (p_free) else $error("gpio lost");
   a_hold: assert property (p_hold) else $error("pin not driven");
   a_swap: assert property (p_swap) else $error("no discharge");
   a_refill: assert property (p_refill) else $error("no charge");
   a_shOn: assert property (p_shOn) else $error("out pin idle");
   a_shOff: assert property (p_shOff) else $error("out pin taken");
   a_stop: assert property (p_stop) else $error("osc runs");
   a_wake: assert property (p_wake) else $error("wake raised");
endmodule : rfc_top_sva
bind rfc_top rfc_top_sva #(.NCHAN(NCHAN)) u_sva (
   .clk(clk), .rstn(rstn), .regAddr(regAddr), .regWdata(regWdata),
   .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .chanIn(chanIn),
   .gpioOut(gpioOut), .gpioOe(gpioOe), .chanOut(chanOut), .chanOe(chanOe),
   .sharedGpioOe(sharedGpioOe), .sharedOe(sharedOe),
   .oscClkOut(oscClkOut), .wakeReq(wakeReq)
);

// ---- rfc_top_tb.sv ----
// Self-checking bench for the converter top with an RC network on its pins.
// Assumes the design, checker and RC model are compiled before it.
`timescale 1ns/1ns
module rfc_top_tb;
   logic clk = 0, rstn = 0, regWr = 0, regRd = 0, captureStart = 0;
   logic greenMode = 0, sharedGpioOut = 0, sharedGpioOe = 0, oscClkOut;
   logic captureDone, wakeReq, sharedOut, sharedOe;
   logic [7:0] regAddr = 8'h00, regWdata = 8'h00, regRdata;
   logic [4:0] chanIn, gpioOut = 5'h0a, gpioOe = 5'h00, chanOut, chanOe;
   logic [1:0] captureSel = 2'h0;
   logic [15:0] captureValue;
   int bad_count = 0, check_count = 0, cyc = 0;
   rfc_top dut (
      .clk(clk), .rstn(rstn), .regAddr(regAddr), .regWdata(regWdata),
      .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .chanIn(chanIn),
      .gpioOut(gpioOut), .gpioOe(gpioOe), .chanOut(chanOut), .chanOe(chanOe),
      .sharedGpioOut(sharedGpioOut), .sharedGpioOe(sharedGpioOe),
      .sharedOut(sharedOut), .sharedOe(sharedOe), .captureSel(captureSel),
      .captureStart(captureStart), .greenMode(greenMode),
      .oscClkOut(oscClkOut), .captureValue(captureValue),
      .captureDone(captureDone), .wakeReq(wakeReq)
   );
   rfc_rc_model rc (.clk(clk), .drv(chanOut), .drvOe(chanOe), .level(chanIn));
   initial forever #5 clk = ~clk;
   task chk(input string n, input logic [15:0] e, input logic [15:0] g);
      check_count++;
      if (g !== e) begin
         bad_count++;
         $display("wrong value %s expected %h seen %h", n, e, g);
      end
   endtask : chk
   task wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      regWr <= 1'b1;
      regAddr <= a;
      regWdata <= d;
      @(posedge clk);
      regWr <= 1'b0;
   endtask : wr
   task rd(input logic [7:0] a, input logic [7:0] e, input string n);
      @(posedge clk);
      regRd <= 1'b1;
      regAddr <= a;
      @(posedge clk);
      regRd <= 1'b0;
      #1 chk(n, {8'h00, e}, {8'h00, regRdata});
   endtask : rd
   task t_regs;
      rd(8'ha6, 8'h00, "reset ctrl");
      wr(8'ha6, 8'h9f);
      rd(8'ha6, 8'h8f, "ctrl");
      rd(8'h55, 8'h00, "unmapped");
   endtask : t_regs
   task t_select;
      logic [4:0] e;
      for (int k = 0; k < 16; k++) begin
         e = (k > 7 && k < 13) ? 5'h01 << (k - 8) : 5'h00;
         wr(8'ha6, {k[3], 3'h1, 1'b0, k[2:0]});
         repeat (6) @(posedge clk);
         chk("pin oe", {11'h0, e}, {11'h0, chanOe});
         chk("pin out", {11'h0, gpioOut & ~e}, {11'h0, chanOut & ~e});
      end
   endtask : t_select
   task t_osc;
      int n;
      logic [15:0] w [4];
      n = 0;
      greenMode <= 1'b1;
      gpioOe <= 5'h00;
      wr(8'ha6, 8'h90);
      repeat (300) @(posedge clk) n += (chanOut[0] && !chanIn[0]);
      chk("osc busy", 16'h1, {15'h0, n > 20});
      chk("wake", 16'h0, {15'h0, wakeReq});
      for (int s = 1; s < 4; s++) begin
         captureSel <= s[1:0];
         captureStart <= 1'b1;
         @(posedge clk) captureStart <= 1'b0;
         n = 0;
         while (captureDone !== 1'b1 && n < 200) @(posedge clk) n++;
         chk("capture", 16'h1, {15'h0, captureValue > 0 && n < 200});
         w[s] = captureValue;
      end
      chk("width sum", w[1] + w[2], w[3]);
      wr(8'ha6, 8'h10);
      repeat (6) @(posedge clk);
      chk("stop oe", 16'h0, {11'h0, chanOe});
   endtask : t_osc
   task t_shared;
      int n;
      logic last;
      n = 0;
      last = 1'b0;
      wr(8'ha6, 8'h98);
      repeat (6) @(posedge clk);
      chk("osc out", 16'h1, {15'h0, sharedOe});
      repeat (60) begin
         @(posedge clk);
         n += (oscClkOut != last);
         last = oscClkOut;
         chk("osc pin", {15'h0, oscClkOut}, {15'h0, sharedOut});
      end
      chk("osc clock", 16'h1, {15'h0, n > 4});
      wr(8'ha6, 8'h10);
      sharedGpioOe <= 1'b1;
      sharedGpioOut <= 1'b1;
      repeat (6) @(posedge clk);
      chk("gpio out", 16'h3, {14'h0, sharedOe, sharedOut});
   endtask : t_shared
   task print_verdict;
      if (bad_count == 0 && check_count > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : print_verdict
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         bad_count++;
         print_verdict;
      end
   end
   initial begin
      repeat (10) @(posedge clk);
      rstn <= 1'b1;
      t_regs;
      t_select;
      t_osc;
      t_shared;
      print_verdict;
   end
endmodule : rfc_top_tb
